// *** src/clock_failure_monitor_pkg.sv ***
package clock_failure_monitor_pkg;

    localparam int          ADDR_W        = 8;

    // Register byte addresses
    localparam logic [7:0]  ADDR_OSC_EN   = 8'h00;
    localparam logic [7:0]  ADDR_CCON     = 8'h04;
    localparam logic [7:0]  ADDR_STATUS   = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_EN   = 8'h0c;

    // Manual enable register
    localparam int          BIT_EXT_ON    = 7;
    localparam int          BIT_HF_ON     = 6;
    localparam int          BIT_LF_ON     = 4;
    localparam int          BIT_SEC_ON    = 3;
    localparam int          BIT_CONV_ON   = 2;
    localparam logic [7:0]  OSC_EN_WMASK  = 8'hdc;
    localparam logic [7:0]  OSC_EN_RST    = 8'h00;

    // Clock control register: source in [6:4], divider in [3:0]
    localparam int          NSRC_LSB      = 4;
    localparam int          NEW_CLOCK_DIVIDER_FIELD_LSB      = 0;
    localparam logic [2:0]  NSRC_RST      = 3'h4;
    localparam logic [3:0]  NEW_CLOCK_DIVIDER_FIELD_RST      = 4'h0;

    // Clock source codes
    localparam logic [2:0]  SRC_EXT_PLL   = 3'h1;
    localparam logic [2:0]  SRC_SOSC      = 3'h2;
    localparam logic [2:0]  SRC_LFINT     = 3'h3;
    localparam logic [2:0]  SRC_HFINT     = 3'h4;
    localparam logic [2:0]  SRC_EXT       = 3'h5;
    localparam logic [3:0]  DIV_NONE      = 4'h0;

    // Status register
    localparam int          ST_FLAG_BIT   = 0;
    localparam int          ST_ACTIVE_BIT = 1;
    localparam int          ST_OST_BIT    = 2;
    localparam int          ST_LATCH_BIT  = 3;
    localparam int          ST_SRC_LSB    = 4;

    // Interrupt enable register
    localparam int          IRQ_EN_BIT    = 0;

    // Monitor and start-up timing
    localparam int          SAMPLE_DIV    = 64;
    localparam int          OST_CYCLES    = 1024;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_OST  = 3'b010,
        ST_FAIL = 3'b100
    } clock_failure_monitor_state_t;

endpackage

// *** src/clock_failure_monitor_det_if.sv ***
`timescale 1ns/1ps
interface clock_failure_monitor_det_if;
    logic monitor_en;
    logic ext_fall;
    logic fail;
    logic latch;
    logic samp;

    modport det (input monitor_en, output ext_fall, output fail, output latch, output samp);
    modport ctl (output monitor_en, input ext_fall, input fail, input latch, input samp);
endinterface

// *** src/clock_failure_monitor_detector.sv ***
`timescale 1ns/1ps
module clock_failure_monitor_detector #(
    parameter int SAMPLE_DIV = clock_failure_monitor_pkg::SAMPLE_DIV
) (
    input  wire logic   clock,
    input  wire logic   nrst,
    input  wire logic   ext_clk_pin,
    input  wire logic   lfosc_pin,
    clock_failure_monitor_det_if.det     det
);
    import clock_failure_monitor_pkg::*;

    localparam int HALF = SAMPLE_DIV / 2;
    localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;

    if (SAMPLE_DIV < 4 || (SAMPLE_DIV % 2) != 0) begin : g_bad_div
        $error("Sample divider must be even and at least 4");
    end

    logic           ext_s1_r, ext_s2_r, ext_s3_r;
    logic           lf_s1_r, lf_s2_r, lf_s3_r;
    logic [CW-1:0]  div_cnt_r;
    logic           samp_r, samp_d_r;
    logic           latch_r;
    logic           fail_r;
    logic           ext_fall, lf_rise, samp_rise, samp_fall;

    ////////////////////////////////////////////////////////////////////////////
    // Both oscillators are far slower than the system clock, so edges are found
    // after two flops; the first flop feeds nothing but the second
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            lf_s1_r  <= 1'b0;
            lf_s2_r  <= 1'b0;
            lf_s3_r  <= 1'b0;
        end else begin
            ext_s1_r <= ext_clk_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            lf_s1_r  <= lfosc_pin;
            lf_s2_r  <= lf_s1_r;
            lf_s3_r  <= lf_s2_r;
        end
    end

    assign ext_fall = ext_s3_r & ~ext_s2_r;
    assign lf_rise  = lf_s2_r & ~lf_s3_r;

    ////////////////////////////////////////////////////////////////////////////
    // divide by 64
    always_ff @(posedge clock) begin
        if (!nrst) begin
            div_cnt_r <= '0;
            samp_r    <= 1'b0;
        end else if (lf_rise) begin
            if (div_cnt_r == CW'(HALF - 1)) begin
                div_cnt_r <= '0;
                samp_r    <= ~samp_r;
            end else begin
                div_cnt_r <= div_cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            samp_d_r <= 1'b0;
        end else begin
            samp_d_r <= samp_r;
        end
    end

    assign samp_rise = samp_r & ~samp_d_r;
    assign samp_fall = ~samp_r & samp_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // set beats clear
    always_ff @(posedge clock) begin
        if (!nrst) begin
            latch_r <= 1'b1;
        end else if (!det.monitor_en || ext_fall) begin
            latch_r <= 1'b1;
        end else if (samp_rise) begin
            latch_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            fail_r <= 1'b0;
        end else begin
            fail_r <= det.monitor_en & samp_fall & ~latch_r;
        end
    end

    assign det.ext_fall = ext_fall;
    assign det.fail     = fail_r;
    assign det.latch    = latch_r;
    assign det.samp     = samp_r;

    ////////////////////////////////////////////////////////////////////////////
    AST_DIV_TOGGLE: assert property (@(posedge clock) disable iff (!nrst)
        (samp_r != $past(samp_r)) |-> $past(lf_rise) && ($past(div_cnt_r) == CW'(HALF - 1)))
        else $error("Sample clock toggled off the divider terminal count");
    AST_LATCH_SET: assert property (@(posedge clock) disable iff (!nrst)
        ext_fall |=> latch_r)
        else $error("External falling edge did not set the latch");
    AST_FAIL_CAUSE: assert property (@(posedge clock) disable iff (!nrst)
        fail_r |-> $past(samp_fall) && !$past(latch_r))
        else $error("Failure raised without an untouched half-cycle");
    AST_MON_OFF: assert property (@(posedge clock) disable iff (!nrst)
        !$past(det.monitor_en) |-> !fail_r)
        else $error("Failure raised while monitor disabled");

endmodule // clock_failure_monitor_detector

// *** src/clock_failure_monitor_top.sv ***
`timescale 1ns/1ps
module clock_failure_monitor_top #(
    parameter int OST_CYCLES = clock_failure_monitor_pkg::OST_CYCLES
) (
    input  wire logic                         clock,
    input  wire logic                         nrst,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [clock_failure_monitor_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         ext_clk_pin,
    input  wire logic                         lfosc_pin,
    input  wire logic                         failure_monitor_config_enable,
    input  wire logic                         sleep_exec,
    output logic                              irq,
    output logic      [2:0]                   sys_clk_src,
    output logic      [3:0]                   sys_clk_div,
    output logic                              hf_1mhz_sel,
    output logic                              fail_safe_active,
    output logic                              ost_running,
    output logic                              external_osc_force_on,
    output logic                              high_freq_osc_force_on,
    output logic                              low_freq_osc_force_on,
    output logic                              secondary_osc_force_on,
    output logic                              converter_osc_force_on
);
    import clock_failure_monitor_pkg::*;

    localparam int OST_W = (OST_CYCLES > 1) ? $clog2(OST_CYCLES) : 1;

    if (OST_CYCLES < 2) begin : g_bad_ost
        $error("Start-up timer needs at least two oscillator cycles");
    end

    clock_failure_monitor_det_if det_if ();

    logic               cfg_s1_r, cfg_s2_r;
    logic [7:0]         osc_en_r;
    logic [2:0]         nsrc_r;
    logic [3:0]         new_clock_divider_field_r;
    logic               irq_en_r;
    logic               flag_r;
    clock_failure_monitor_state_t        state_r;
    logic [2:0]         cur_src_r;
    logic [3:0]         cur_div_r;
    logic [OST_W-1:0]   ost_cnt_r;
    logic [31:0]        prdata_r;
    logic [31:0]        rdata_mux;

    logic               setup, access, wr;
    logic               mapped;
    logic               wr_osc_en, wr_ccon, wr_status, wr_irq_en;
    logic [2:0]         new_src;
    logic [3:0]         new_div;
    logic               ccon_change;
    logic               restart;
    logic [2:0]         tgt_src;
    logic [3:0]         tgt_div;
    logic               det_fail;

    function automatic logic needs_ost(input logic [2:0] src);
        needs_ost = (src == SRC_EXT) || (src == SRC_EXT_PLL);
    endfunction

    function automatic logic is_monitored(input logic [2:0] src);
        is_monitored = (src == SRC_EXT) || (src == SRC_EXT_PLL) || (src == SRC_SOSC);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration strap is a pin and is resynchronised before use
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cfg_s1_r <= 1'b0;
            cfg_s2_r <= 1'b0;
        end else begin
            cfg_s1_r <= failure_monitor_config_enable;
            cfg_s2_r <= cfg_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, read data captured in the setup cycle
    assign setup     = psel & ~penable;
    assign access    = psel & penable;
    assign wr        = access & pwrite;
    assign mapped    = (paddr == ADDR_OSC_EN) || (paddr == ADDR_CCON) ||
                       (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_EN);
    assign wr_osc_en = wr & (paddr == ADDR_OSC_EN);
    assign wr_ccon   = wr & (paddr == ADDR_CCON);
    assign wr_status = wr & (paddr == ADDR_STATUS);
    assign wr_irq_en = wr & (paddr == ADDR_IRQ_EN);

    assign pready    = 1'b1;
    assign pslverr   = access & ~mapped;
    assign prdata    = prdata_r;

    always_comb begin
        rdata_mux = '0;
        unique case (paddr)
            ADDR_OSC_EN: rdata_mux[7:0] = osc_en_r;
            ADDR_CCON: begin
                rdata_mux[NSRC_LSB +: 3] = nsrc_r;
                rdata_mux[NEW_CLOCK_DIVIDER_FIELD_LSB +: 4] = new_clock_divider_field_r;
            end
            ADDR_STATUS: begin
                rdata_mux[ST_FLAG_BIT]     = flag_r;
                rdata_mux[ST_ACTIVE_BIT]   = (state_r == ST_FAIL);
                rdata_mux[ST_OST_BIT]      = (state_r == ST_OST);
                rdata_mux[ST_LATCH_BIT]    = det_if.latch;
                rdata_mux[ST_SRC_LSB +: 3] = cur_src_r;
            end
            ADDR_IRQ_EN: rdata_mux[IRQ_EN_BIT] = irq_en_r;
            default:     rdata_mux = '0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata_r <= '0;
        end else if (setup) begin
            prdata_r <= rdata_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Manual enable register
    // unimplemented bits masked
    always_ff @(posedge clock) begin
        if (!nrst) begin
            osc_en_r <= OSC_EN_RST;
        end else if (wr_osc_en) begin
            osc_en_r <= pwdata[7:0] & OSC_EN_WMASK;
        end
    end

    assign external_osc_force_on  = osc_en_r[BIT_EXT_ON];
    assign high_freq_osc_force_on = osc_en_r[BIT_HF_ON];
    assign low_freq_osc_force_on  = osc_en_r[BIT_LF_ON];
    assign secondary_osc_force_on = osc_en_r[BIT_SEC_ON];
    assign converter_osc_force_on = osc_en_r[BIT_CONV_ON];

    ////////////////////////////////////////////////////////////////////////////
    // Clock control fields and interrupt enable
    assign new_src     = pwdata[NSRC_LSB +: 3];
    assign new_div     = pwdata[NEW_CLOCK_DIVIDER_FIELD_LSB +: 4];
    // A rewrite of identical fields is not a change and leaves the state alone
    assign ccon_change = wr_ccon & ({new_src, new_div} != {nsrc_r, new_clock_divider_field_r});
    assign restart     = ccon_change | sleep_exec;
    assign tgt_src     = ccon_change ? new_src : nsrc_r;
    assign tgt_div     = ccon_change ? new_div : new_clock_divider_field_r;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            nsrc_r <= NSRC_RST;
            new_clock_divider_field_r <= NEW_CLOCK_DIVIDER_FIELD_RST;
        end else if (wr_ccon) begin
            nsrc_r <= new_src;
            new_clock_divider_field_r <= new_div;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_en_r <= 1'b0;
        end else if (wr_irq_en) begin
            irq_en_r <= pwdata[IRQ_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Failure detector
    // monitor gated by config
    assign det_if.monitor_en = cfg_s2_r &
                               (((state_r == ST_RUN) && is_monitored(cur_src_r)) || (state_r == ST_OST));
    assign det_fail          = det_if.fail;

    clock_failure_monitor_detector #(
        .SAMPLE_DIV (SAMPLE_DIV)
    ) u_det (
        .clock       (clock),
        .nrst        (nrst),
        .ext_clk_pin (ext_clk_pin),
        .lfosc_pin   (lfosc_pin),
        .det         (det_if.det)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock switching; a firmware restart outranks a failure seen the same cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_r   <= ST_RUN;
            cur_src_r <= NSRC_RST;
            cur_div_r <= NEW_CLOCK_DIVIDER_FIELD_RST;
            ost_cnt_r <= '0;
        end else if (restart) begin
            if (needs_ost(tgt_src)) begin
                state_r   <= ST_OST;
                ost_cnt_r <= '0;
            end else begin
                state_r   <= ST_RUN;
                cur_src_r <= tgt_src;
                cur_div_r <= tgt_div;
            end
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    if (det_fail) begin
                        state_r   <= ST_FAIL;
                        cur_src_r <= SRC_HFINT;
                        cur_div_r <= DIV_NONE;
                    end
                end
                ST_OST: begin
                    if (det_fail) begin
                        state_r   <= ST_FAIL;
                        cur_src_r <= SRC_HFINT;
                        cur_div_r <= DIV_NONE;
                    end else if (det_if.ext_fall) begin
                        if (ost_cnt_r == OST_W'(OST_CYCLES - 1)) begin
                            state_r   <= ST_RUN;
                            cur_src_r <= nsrc_r;
                            cur_div_r <= new_clock_divider_field_r;
                        end else begin
                            ost_cnt_r <= ost_cnt_r + OST_W'(1);
                        end
                    end
                end
                ST_FAIL: state_r <= ST_FAIL;
                default: state_r <= ST_RUN;
            endcase
        end
    end

    assign sys_clk_src      = cur_src_r;
    assign sys_clk_div      = cur_div_r;
    assign fail_safe_active = (state_r == ST_FAIL);
    assign hf_1mhz_sel      = (state_r == ST_FAIL);
    assign ost_running      = (state_r == ST_OST);

    ////////////////////////////////////////////////////////////////////////////
    // Failure flag; hardware set wins over a software clear in the same cycle
    // sticky until written zero
    always_ff @(posedge clock) begin
        if (!nrst) begin
            flag_r <= 1'b0;
        end else if (det_fail) begin
            flag_r <= 1'b1;
        end else if (wr_status && !pwdata[ST_FLAG_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    assign irq = flag_r & irq_en_r;

    ////////////////////////////////////////////////////////////////////////////
    AST_SWITCH_HF: assert property (@(posedge clock) disable iff (!nrst)
        (det_fail && !restart && state_r == ST_RUN) |=> (cur_src_r == SRC_HFINT) && hf_1mhz_sel && flag_r)
        else $error("Failure did not move the clock to the 1 MHz internal source");
    AST_IRQ_RAISE: assert property (@(posedge clock) disable iff (!nrst)
        (det_fail && irq_en_r && !wr_irq_en) |=> irq)
        else $error("Interrupt not raised for an enabled failure flag");
    AST_STAY_INT: assert property (@(posedge clock) disable iff (!nrst)
        (state_r == ST_FAIL && !restart) |=> (state_r == ST_FAIL) && (cur_src_r == SRC_HFINT))
        else $error("Left fail-safe without a firmware restart");
    AST_SLEEP_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
        sleep_exec |=> !fail_safe_active)
        else $error("Sleep did not clear the fail-safe condition");
    AST_OST_START: assert property (@(posedge clock) disable iff (!nrst)
        (ccon_change && needs_ost(new_src)) |=> ost_running && (ost_cnt_r == '0))
        else $error("External request did not restart the start-up timer");
    AST_OST_HOLD: assert property (@(posedge clock) disable iff (!nrst)
        (ost_running && $past(ost_running) && !$past(restart)) |-> $stable(cur_src_r))
        else $error("Clock source changed while the start-up timer ran");
    AST_OST_DONE: assert property (@(posedge clock) disable iff (!nrst)
        (ost_running && !restart && !det_fail && det_if.ext_fall && ost_cnt_r == OST_W'(OST_CYCLES - 1))
        |=> (state_r == ST_RUN) && (cur_src_r == nsrc_r))
        else $error("Start-up timer expiry did not complete the switch");
    AST_RETRY_FAIL: assert property (@(posedge clock) disable iff (!nrst)
        (ost_running && det_fail && !restart) |=> flag_r && fail_safe_active)
        else $error("Persisting failure did not set the flag again");
    AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (!nrst)
        (flag_r && !(wr_status && !pwdata[ST_FLAG_BIT])) |=> flag_r)
        else $error("Failure flag dropped without a software clear");
    AST_CLR_KEEPS_SRC: assert property (@(posedge clock) disable iff (!nrst)
        (wr_status && !restart && !det_fail && state_r == ST_FAIL) |=> $stable(cur_src_r))
        else $error("Flag clear changed the clock source");
    AST_FORCE_BITS: assert property (@(posedge clock) disable iff (!nrst)
        wr_osc_en |=> (external_osc_force_on == $past(pwdata[BIT_EXT_ON])) &&
                      (osc_en_r[5] == 1'b0) && (osc_en_r[1:0] == 2'h0))
        else $error("Manual enable register did not follow the write");
    AST_FORCE_OTHERS: assert property (@(posedge clock) disable iff (!nrst)
        wr_osc_en |=> (secondary_osc_force_on == $past(pwdata[BIT_SEC_ON])) &&
                      (converter_osc_force_on == $past(pwdata[BIT_CONV_ON])) &&
                      (high_freq_osc_force_on == $past(pwdata[BIT_HF_ON])) &&
                      (low_freq_osc_force_on == $past(pwdata[BIT_LF_ON])))
        else $error("Force-on outputs did not follow the manual enable write");

endmodule // clock_failure_monitor_top

// *** test/clock_failure_monitor_ext_osc.sv ***
`timescale 1ns/1ps
// External crystal model; stopped, it parks high so no falling edge can reach the latch
module clock_failure_monitor_ext_osc #(
    parameter int HALF_NS = 200
) (
    input  wire logic run,
    output logic      osc_out
);
    initial begin
        osc_out = 1'b1;
        forever begin
            #(HALF_NS);
            osc_out = run ? ~osc_out : 1'b1;
        end
    end
endmodule // clock_failure_monitor_ext_osc

// *** test/fail_safe_clock_monitor_bench.sv ***
`timescale 1ns/1ps
module fail_safe_clock_monitor_bench;
    import clock_failure_monitor_pkg::*;
    logic        clock = 0, nrst = 0, lfosc = 0, cfg_en = 1, sleep_exec = 0, run = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, irq, hf_sel, fs_act, ost_on, ext_clk;
    logic [2:0]  src;
    logic [3:0]  div;
    wire  [4:0]  fon;
    int          n_mismatch = 0, n_compared = 0;

    always #10 clock = ~clock;
    // Slow oscillator: sample half period is 32 x 8 = 256 system cycles
    always #80 lfosc = ~lfosc;

    clock_failure_monitor_ext_osc #(.HALF_NS(200)) osc (.run(run), .osc_out(ext_clk));
    // Short start-up count keeps each restart near 80 cycles
    clock_failure_monitor_top #(.OST_CYCLES(4)) uut (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk),
        .lfosc_pin(lfosc), .failure_monitor_config_enable(cfg_en), .sleep_exec(sleep_exec), .irq(irq),
        .sys_clk_src(src), .sys_clk_div(div), .hf_1mhz_sel(hf_sel), .fail_safe_active(fs_act),
        .ost_running(ost_on), .external_osc_force_on(fon[4]), .high_freq_osc_force_on(fon[3]),
        .low_freq_osc_force_on(fon[2]), .secondary_osc_force_on(fon[1]), .converter_osc_force_on(fon[0]));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20) begin
            chk("apb wait", 0, 1);
            test_done();
        end
    endtask

    // Bounded wait on fail-safe (0), start-up timer (1) or interrupt (2)
    task automatic wait_for(input int sel, input logic val, input int lim);
        logic s;
        for (int i = 0; i < lim; i++) begin
            @(posedge clock);
            s = (sel == 0) ? fs_act : (sel == 1) ? ost_on : irq;
            if (s === val) return;
        end
        chk("wait", 0, 1);
        test_done();
    endtask

    function automatic logic [31:0] exp_en(input logic [7:0] d);
        return {24'h0, d & OSC_EN_WMASK};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        void'($urandom(53090));
        repeat (2) @(posedge clock);
        nrst <= 1;
        repeat (4) @(posedge clock);
        apb(0, ADDR_OSC_EN, 0);
        chk("osc_en rst", rd, 0);
        apb(0, ADDR_CCON, 0);
        chk("ccon rst", rd, 32'h40);
        apb(0, ADDR_STATUS, 0);
        chk("status rst", rd & 32'hf7, 32'h40);
        apb(1, 8'h10, 32'hff);
        chk("unmapped err", err, 1);
        apb(0, 8'h10, 0);
        chk("unmapped rd", rd, 0);
        for (int i = 0; i < 8; i++) begin
            d = (i < 2) ? {8{i == 0}} : 8'($urandom);
            apb(1, ADDR_OSC_EN, {24'h0, d});
            apb(0, ADDR_OSC_EN, 0);
            chk("osc_en", rd, exp_en(d));
            chk("force_on", fon, {d[7], d[6], d[4], d[3], d[2]});
        end
        apb(1, ADDR_IRQ_EN, 1);
        apb(1, ADDR_CCON, 32'h50);
        wait_for(1, 1, 20);
        chk("src in ost", src, SRC_HFINT);
        wait_for(1, 0, 500);
        chk("src ext", src, SRC_EXT);
        cfg_en <= 0;
        run <= 0;
        repeat (1500) @(posedge clock);
        chk("monitor off", fs_act, 0);
        cfg_en <= 1;
        wait_for(0, 1, 2000);
        chk("hf sel", hf_sel, 1);
        chk("src fail", src, SRC_HFINT);
        chk("irq", irq, 1);
        apb(0, ADDR_STATUS, 0);
        chk("flag", rd[0], 1);
        apb(1, ADDR_STATUS, 0);
        apb(0, ADDR_STATUS, 0);
        chk("flag clr", rd[0], 0);
        chk("irq clr", irq, 0);
        chk("src kept", src, SRC_HFINT);
        // Reset in mid-run drops the fail-safe condition and restarts the sample divider
        nrst <= 0;
        repeat (3) @(posedge clock);
        nrst <= 1;
        repeat (4) @(posedge clock);
        apb(0, ADDR_STATUS, 0);
        chk("status mid rst", rd & 32'hf7, 32'h40);
        apb(1, ADDR_IRQ_EN, 1);
        // Restart towards a dead crystal must fail again, one full sample period after reset
        apb(1, ADDR_CCON, 32'h10);
        repeat (480) @(posedge clock);
        chk("no early fail", irq, 0);
        wait_for(2, 1, 200);
        apb(0, ADDR_STATUS, 0);
        chk("flag again", rd[0], 1);
        chk("src internal", src, SRC_HFINT);
        run <= 1;
        repeat (50) @(posedge clock);
        sleep_exec <= 1;
        @(posedge clock);
        sleep_exec <= 0;
        wait_for(1, 1, 20);
        wait_for(1, 0, 500);
        chk("src pll", src, SRC_EXT_PLL);
        chk("fs cleared", fs_act, 0);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            apb(1, ADDR_CCON, {28'h4, d[3:0]});
            apb(0, ADDR_CCON, 0);
            chk("ccon", rd, {28'h4, d[3:0]});
            chk("div", div, d[3:0]);
        end
        test_done();
    end
endmodule // fail_safe_clock_monitor_bench
